/* design/plpc_pkg.sv */
`default_nettype none
package plpc_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 250;
  // Register indexes, byte address is four times the index
  localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
  localparam logic [4:0] IDX_PLL_CTRL = 5'h10;
  localparam logic [4:0] IDX_OSC_CTRL = 5'h11;
  localparam logic [4:0] IDX_SLEEP_CTRL = 5'h18;
  localparam logic [4:0] IDX_PM_EXT = 5'h19;
  localparam logic [4:0] IDX_PM_STAT = 5'h1A;
  localparam logic [4:0] IDX_PHY_CTRL2 = 5'h1F;
  // Field positions
  localparam int unsigned BIT_SOFT_RESET = 15;
  localparam int unsigned BIT_AUTONEG_EN = 12;
  localparam int unsigned BIT_POWER_DOWN = 11;
  localparam int unsigned BIT_PLL_OFF = 4;
  localparam int unsigned BIT_SLOW_OSC = 5;
  localparam int unsigned BIT_SLEEP_DIS = 11;
  localparam int unsigned BIT_LONG_PULSE = 0;
  localparam int unsigned BIT_SAVE_EN = 10;
  localparam int unsigned STAT_RX_EN = 0;
  localparam int unsigned STAT_PLL_EN = 1;
  localparam int unsigned STAT_SLOW_SEL = 2;
  localparam int unsigned STAT_SAVE = 3;
  localparam int unsigned STAT_SLEEP = 4;
  localparam int unsigned STAT_WAKE = 5;
  localparam int unsigned STAT_PDOWN = 6;
  localparam int unsigned STAT_LOWEST = 7;
  localparam int unsigned STAT_LINK = 8;
  localparam int unsigned STAT_ENERGY = 9;
  // Reset values
  localparam logic RST_AUTONEG_EN = 1'b1;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_PLL_OFF = 1'b0;
  localparam logic RST_SLOW_OSC = 1'b0;
  localparam logic RST_SLEEP_DIS = 1'b1;
  localparam logic RST_LONG_PULSE = 1'b0;
  localparam logic RST_SAVE_EN = 1'b0;
  // Timing, in microseconds, and derived cycle counts
  localparam int unsigned LINK_PULSE_US = 16000;
  localparam int unsigned LONG_PULSE_US = 64000;
  localparam int unsigned WAKE_US = 2000;
  localparam int unsigned LINK_PULSE_CYCLES = LINK_PULSE_US * CLK_MHZ;
  localparam int unsigned LONG_PULSE_CYCLES = LONG_PULSE_US * CLK_MHZ;
  localparam int unsigned WAKE_CYCLES = WAKE_US * CLK_MHZ;

  // Byte address compare against four times a register index
  function automatic logic addr_hit(input logic [11:0] addr, input logic [4:0] idx);
    return addr == {5'h00, idx, 2'b00};
  endfunction : addr_hit

  // Byte lane enable for a bit position
  function automatic logic lane_en(input logic [3:0] strb, input int unsigned pos);
    return strb[pos / 8];
  endfunction : lane_en
endpackage : plpc_pkg
`default_nettype wire

/* design/plpc_pulse_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_pulse_timer #(
  parameter int unsigned SHORT_CYCLES = 16,
  parameter int unsigned LONG_CYCLES = 64,
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic long_sel,
  // Pulse out
  output logic tick
);
  logic [W-1:0] count;

  // Interval counter, reloaded while stopped so the first pulse comes a full interval in
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run) begin
      count <= '0;
    end else if (count == W'(long_sel ? LONG_CYCLES - 1 : SHORT_CYCLES - 1)) begin
      count <= '0;
    end else begin
      count <= count + W'(1);
    end
  end

  // One-cycle tick at the end of each interval
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (count == W'(long_sel ? LONG_CYCLES - 1 : SHORT_CYCLES - 1));
    end
  end
endmodule : plpc_pulse_timer
`default_nettype wire

/* design/plpc_top.sv */
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Power-saving armed by bit; acts when idle
// - Power-saving keeps transmitter, energy detect, PLL
// - Power-saving enable resets cleared
// - Energy sleep armed by zero; acts when idle
// - PLL-off bit stops PLL during energy sleep
// - Energy sleep sends periodic link pulses
// - Energy sleep disable bit resets to one
// - Power-down bit set enters power-down
// - Power-down stops all but management access; here the crystal input stays enabled unless the slow oscillator is selected
// - Clearing power-down bit leaves power-down
// - Slow-oscillator bit swaps reference for slow clock
// - Slow oscillator plus power-down: lowest power
// - All mode bits reachable over management bus
module plpc_top #(
  parameter int unsigned PULSE_CYCLES = plpc_pkg::LINK_PULSE_CYCLES,
  parameter int unsigned LONG_CYCLES = plpc_pkg::LONG_PULSE_CYCLES,
  parameter int unsigned WAKE_CYCLES = plpc_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line status
  input wire logic link_up,
  input wire logic energy_det,
  // Transceiver block controls
  output logic rx_path_en,
  output logic tx_path_en,
  output logic energy_det_en,
  output logic pll_en,
  output logic core_func_en,
  output logic ref_slow_sel,
  output logic ref_crystal_input_en,
  output logic autoneg_restart,
  output logic link_pulse,
  output logic soft_reset
);
  import plpc_pkg::*;

  typedef enum logic [2:0] {ST_NORMAL, ST_SAVE, ST_SLEEP, ST_WAKE, ST_PDOWN} plpc_state_type;

  localparam int unsigned WAKE_W = $clog2(WAKE_CYCLES + 1);

  plpc_state_type state;
  plpc_state_type next_state;
  logic autoneg_en;
  logic power_down;
  logic pll_off;
  logic slow_osc;
  logic sleep_dis;
  logic long_pulse;
  logic save_en;
  logic [WAKE_W-1:0] wake_cnt;
  logic setup;
  logic wr;
  logic mapped;
  logic reset_req;
  logic idle;
  logic tick;
  logic [31:0] rd_word;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // APB phase decode; writes land only in the access cycle with pready high
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;
  assign mapped = addr_hit(paddr, IDX_BASIC_CTRL) || addr_hit(paddr, IDX_PLL_CTRL) ||
                  addr_hit(paddr, IDX_OSC_CTRL) || addr_hit(paddr, IDX_SLEEP_CTRL) ||
                  addr_hit(paddr, IDX_PM_EXT) || addr_hit(paddr, IDX_PM_STAT) ||
                  addr_hit(paddr, IDX_PHY_CTRL2);
  assign reset_req = wr && addr_hit(paddr, IDX_BASIC_CTRL) && lane_en(pstrb, BIT_SOFT_RESET) &&
                     pwdata[BIT_SOFT_RESET];

  // Ready and error, one access cycle per transfer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // Basic control bits; a software reset returns every mode bit to default
  always_ff @(posedge clk_sys) begin
    if (!rst_b || reset_req) begin
      autoneg_en <= RST_AUTONEG_EN;
      power_down <= RST_POWER_DOWN;
    end else if (wr && addr_hit(paddr, IDX_BASIC_CTRL)) begin
      if (lane_en(pstrb, BIT_AUTONEG_EN)) begin
        autoneg_en <= pwdata[BIT_AUTONEG_EN];
        power_down <= pwdata[BIT_POWER_DOWN];
      end
    end
  end

  // PLL-off and slow-oscillator bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b || reset_req) begin
      pll_off <= RST_PLL_OFF;
      slow_osc <= RST_SLOW_OSC;
    end else begin
      if (wr && addr_hit(paddr, IDX_PLL_CTRL) && lane_en(pstrb, BIT_PLL_OFF)) begin
        pll_off <= pwdata[BIT_PLL_OFF];
      end
      if (wr && addr_hit(paddr, IDX_OSC_CTRL) && lane_en(pstrb, BIT_SLOW_OSC)) begin
        slow_osc <= pwdata[BIT_SLOW_OSC];
      end
    end
  end

  // Low-power arming bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b || reset_req) begin
      sleep_dis <= RST_SLEEP_DIS;
      long_pulse <= RST_LONG_PULSE;
      save_en <= RST_SAVE_EN;
    end else begin
      if (wr && addr_hit(paddr, IDX_SLEEP_CTRL) && lane_en(pstrb, BIT_SLEEP_DIS)) begin
        sleep_dis <= pwdata[BIT_SLEEP_DIS];
      end
      if (wr && addr_hit(paddr, IDX_PM_EXT) && lane_en(pstrb, BIT_LONG_PULSE)) begin
        long_pulse <= pwdata[BIT_LONG_PULSE];
      end
      if (wr && addr_hit(paddr, IDX_PHY_CTRL2) && lane_en(pstrb, BIT_SAVE_EN)) begin
        save_en <= pwdata[BIT_SAVE_EN];
      end
    end
  end

  // Read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_hit(paddr, IDX_BASIC_CTRL)) begin
      rd_word[BIT_AUTONEG_EN] = autoneg_en;
      rd_word[BIT_POWER_DOWN] = power_down;
    end
    if (addr_hit(paddr, IDX_PLL_CTRL)) begin
      rd_word[BIT_PLL_OFF] = pll_off;
    end
    if (addr_hit(paddr, IDX_OSC_CTRL)) begin
      rd_word[BIT_SLOW_OSC] = slow_osc;
    end
    if (addr_hit(paddr, IDX_SLEEP_CTRL)) begin
      rd_word[BIT_SLEEP_DIS] = sleep_dis;
    end
    if (addr_hit(paddr, IDX_PM_EXT)) begin
      rd_word[BIT_LONG_PULSE] = long_pulse;
    end
    if (addr_hit(paddr, IDX_PHY_CTRL2)) begin
      rd_word[BIT_SAVE_EN] = save_en;
    end
    if (addr_hit(paddr, IDX_PM_STAT)) begin
      rd_word[STAT_RX_EN] = rx_path_en;
      rd_word[STAT_PLL_EN] = pll_en;
      rd_word[STAT_SLOW_SEL] = ref_slow_sel;
      rd_word[STAT_SAVE] = state == ST_SAVE;
      rd_word[STAT_SLEEP] = state == ST_SLEEP;
      rd_word[STAT_WAKE] = state == ST_WAKE;
      rd_word[STAT_PDOWN] = state == ST_PDOWN;
      rd_word[STAT_LOWEST] = state == ST_PDOWN && ref_slow_sel;
      rd_word[STAT_LINK] = link_up;
      rd_word[STAT_ENERGY] = energy_det;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
    end
  end

  // Cable idle: auto-negotiation on and no link
  assign idle = autoneg_en && !link_up;

  // Mode selection; power-down overrides every other mode
  always_comb begin
    next_state = state;
    unique case (state)
      ST_NORMAL: begin
        if (idle && !sleep_dis) begin
          next_state = ST_SLEEP;
        end else if (idle && save_en) begin
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (energy_det) begin
          next_state = ST_WAKE;
        end else if (!idle || !save_en) begin
          next_state = ST_NORMAL;
        end else if (!sleep_dis) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (energy_det) begin
          next_state = ST_WAKE;
        end else if (!idle || sleep_dis) begin
          next_state = ST_NORMAL;
        end
      end
      ST_WAKE: begin
        if (link_up || !autoneg_en || wake_cnt == '0) begin
          next_state = ST_NORMAL;
        end
      end
      ST_PDOWN: begin
        if (!power_down) begin
          next_state = ST_NORMAL;
        end
      end
    endcase
    if (power_down) begin
      next_state = ST_PDOWN;
    end
    if (reset_req) begin
      next_state = ST_NORMAL;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Wake window gives auto-negotiation time to bring the link up
  always_ff @(posedge clk_sys) begin
    if (!rst_b || next_state != ST_WAKE) begin
      wake_cnt <= WAKE_W'(WAKE_CYCLES);
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - WAKE_W'(1);
    end
  end

  // Block enables, registered from the next mode
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_path_en <= 1'b1;
      tx_path_en <= 1'b1;
      energy_det_en <= 1'b1;
      pll_en <= 1'b1;
      core_func_en <= 1'b1;
      autoneg_restart <= 1'b0;
    end else begin
      rx_path_en <= next_state == ST_NORMAL || next_state == ST_WAKE;
      tx_path_en <= next_state != ST_PDOWN;
      energy_det_en <= next_state != ST_PDOWN;
      pll_en <= next_state != ST_PDOWN && !(next_state == ST_SLEEP && pll_off);
      core_func_en <= next_state != ST_PDOWN;
      autoneg_restart <= next_state == ST_WAKE && state != ST_WAKE;
    end
  end

  // Reference clock source and software reset pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ref_slow_sel <= 1'b0;
      ref_crystal_input_en <= 1'b1;
      soft_reset <= 1'b0;
      link_pulse <= 1'b0;
    end else begin
      ref_slow_sel <= slow_osc;
      ref_crystal_input_en <= !slow_osc;
      soft_reset <= reset_req;
      link_pulse <= tick;
    end
  end

  // Link pulse interval timer, runs only in energy sleep
  plpc_pulse_timer #(
    .SHORT_CYCLES(PULSE_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .W(32)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(state == ST_SLEEP),
    .long_sel(long_pulse),
    .tick(tick)
  );

  // Rule checks on mode entry, block enables and bus answer
  a_save_needs_idle: assert property ((state == ST_SAVE) |-> $past(save_en && idle))
    else $error("power-saving entered without arming or idle");
  a_save_keeps_blocks: assert property ((state == ST_SAVE) |-> tx_path_en && energy_det_en && pll_en && !rx_path_en)
    else $error("wrong blocks in power-saving");
  a_reset_defaults: assert property (disable iff (1'b0) !rst_b |=> !save_en && sleep_dis && !power_down)
    else $error("mode bits not at reset value");
  a_sleep_needs_arm: assert property ((state == ST_SLEEP) |-> $past(!sleep_dis && idle))
    else $error("energy sleep without arming");
  a_sleep_pll_off: assert property ((state == ST_SLEEP) |-> pll_en == !$past(pll_off))
    else $error("PLL state wrong in energy sleep");
  a_pulse_in_sleep: assert property (link_pulse |-> $past(state == ST_SLEEP, 2) || $past(state == ST_SLEEP, 3))
    else $error("link pulse outside energy sleep");
  a_pdown_entry: assert property ($rose(power_down) |=> !rx_path_en && !pll_en && !core_func_en)
    else $error("power-down not entered");
  a_pdown_exit: assert property ($fell(power_down) && !$past(reset_req) |=> rx_path_en && core_func_en)
    else $error("power-down not left");
  a_slow_osc_sel: assert property ($rose(slow_osc) |=> ref_slow_sel && !ref_crystal_input_en)
    else $error("slow oscillator not selected");
  a_lowest_power: assert property ((state == ST_PDOWN && ref_slow_sel) |-> !pll_en && !tx_path_en)
    else $error("lowest power state leaks");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
  a_wake_restart: assert property ((state == ST_WAKE && $past(state) != ST_WAKE) |-> autoneg_restart && rx_path_en)
    else $error("wake without auto-negotiation restart");
endmodule : plpc_top
`default_nettype wire

/* sim/plpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module plpc_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Set when the slave never answers
  output logic hang
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    hang = 1'b0;
  end

  // One APB transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      hang <= 1'b1;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : plpc_host
`default_nettype wire

/* sim/phy_low_power_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_low_power_control_tb;
  logic clk_sys, rst_b, link_up, energy_det;
  logic psel, penable, pwrite, pready, pslverr, hang;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic rx_path_en, tx_path_en, energy_det_en, pll_en, core_func_en;
  logic ref_slow_sel, ref_crystal_input_en, autoneg_restart, link_pulse, soft_reset;
  logic [6:0] en_vec;
  int failures = 0;
  int checks = 0;
  int restarts = 0;
  int resets = 0;
  int gap;
  logic [11:0] ra [6] = '{12'h000, 12'h040, 12'h044, 12'h060, 12'h064, 12'h07C};
  logic [31:0] rv [6] = '{32'h1000, 32'h0, 32'h0, 32'h0800, 32'h0, 32'h0};

  assign en_vec = {rx_path_en, tx_path_en, energy_det_en, pll_en, core_func_en, ref_slow_sel, ref_crystal_input_en};

  plpc_top #(.PULSE_CYCLES(16), .LONG_CYCLES(64), .WAKE_CYCLES(32)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_up(link_up), .energy_det(energy_det), .rx_path_en(rx_path_en),
    .tx_path_en(tx_path_en), .energy_det_en(energy_det_en), .pll_en(pll_en),
    .core_func_en(core_func_en), .ref_slow_sel(ref_slow_sel),
    .ref_crystal_input_en(ref_crystal_input_en), .autoneg_restart(autoneg_restart),
    .link_pulse(link_pulse), .soft_reset(soft_reset));

  plpc_host host (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hang(hang));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // One-cycle pulse counters and hang cut-off
  always @(posedge clk_sys) begin
    if (autoneg_restart === 1'b1) restarts++;
    if (soft_reset === 1'b1) resets++;
    if (hang === 1'b1) begin
      failures++;
      $display("unexpected at %0t: pready got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, 4'hF, q, e);
  endtask : wr

  // Write with chosen byte lanes
  task automatic wrl(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, s, q, e);
  endtask : wrl

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, 4'hF, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, eerr});
  endtask : rd

  // Settle, then compare the block enables
  task automatic see(input logic [6:0] exp);
    repeat (3) @(posedge clk_sys);
    #1 chk({25'h0, en_vec}, {25'h0, exp});
  endtask : see

  // Cycles from one link pulse to the next
  task automatic pulse_gap(output int n);
    int w;
    w = 0;
    n = 0;
    do begin
      @(posedge clk_sys);
      w++;
    end while (link_pulse !== 1'b1 && w < 200);
    do begin
      @(posedge clk_sys);
      n++;
    end while (link_pulse !== 1'b1 && n < 200);
    // A missing pulse is a mismatch and ends the run
    if (link_pulse !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: link pulse got %h expected %h", $time, link_pulse, 1'b1);
      tally_and_finish();
    end
  endtask : pulse_gap

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_b = 1'b0;
    link_up = 1'b1;
    energy_det = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values and an unmapped address
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i], 1'b0);
    rd(12'h004, 32'h0, 1'b1);
    wrl(12'h064, 32'h0001, 4'h2);
    rd(12'h064, 32'h0, 1'b0);
    wrl(12'h064, 32'h0001, 4'h1);
    rd(12'h064, 32'h1, 1'b0);
    wr(12'h064, 32'h0);
    see(7'h7D);
    $display("test reset done");
    // Power saving: armed, blocked by link, active when idle, woken by energy
    wr(12'h07C, 32'h0400);
    see(7'h7D);
    @(posedge clk_sys) link_up <= 1'b0;
    see(7'h3D);
    rd(12'h068, 32'h000A, 1'b0);
    @(posedge clk_sys) energy_det <= 1'b1;
    see(7'h7D);
    rd(12'h068, 32'h0223, 1'b0);
    @(posedge clk_sys) link_up <= 1'b1;
    @(posedge clk_sys) energy_det <= 1'b0;
    wr(12'h07C, 32'h0);
    see(7'h7D);
    chk(restarts, 1);
    $display("test power saving done");
    // Energy sleep with the PLL off and periodic link pulses
    wr(12'h040, 32'h0010);
    wr(12'h060, 32'h0);
    see(7'h7D);
    wr(12'h000, 32'h0);
    @(posedge clk_sys) link_up <= 1'b0;
    see(7'h7D);
    wr(12'h000, 32'h1000);
    see(7'h35);
    rd(12'h068, 32'h0010, 1'b0);
    pulse_gap(gap);
    chk(gap, 16);
    wr(12'h064, 32'h0001);
    pulse_gap(gap);
    pulse_gap(gap);
    chk(gap, 64);
    wr(12'h060, 32'h0800);
    see(7'h7D);
    wr(12'h040, 32'h0);
    @(posedge clk_sys) link_up <= 1'b1;
    $display("test energy sleep done");
    // Power-down, slow oscillator, then the ordered exit
    wr(12'h000, 32'h1800);
    see(7'h01);
    rd(12'h000, 32'h1800, 1'b0);
    wr(12'h044, 32'h0020);
    see(7'h02);
    rd(12'h068, 32'h01C4, 1'b0);
    wr(12'h044, 32'h0);
    see(7'h01);
    wr(12'h000, 32'h1000);
    see(7'h7D);
    wr(12'h000, 32'h9000);
    see(7'h7D);
    chk(resets, 1);
    rd(12'h064, 32'h0, 1'b0);
    rd(12'h000, 32'h1000, 1'b0);
    $display("test power down done");
    tally_and_finish();
  end
endmodule : phy_low_power_control_tb
`default_nettype wire
